// ===== common/pol_fault_defs.vh
// Purpose: constants for the point-of-load fault supervisor
// Assumes: voltages in millivolts (16 bit), temperature in whole degrees C (8 bit signed-free)
// Notes: register offsets are byte addresses on a 32-bit classic Wishbone slave
`ifndef POL_FAULT_DEFS_VH
`define POL_FAULT_DEFS_VH
`define CLK_MHZ 250
`define QUAL_DELAY_NS 6000
`define QUAL_DELAY_CYC ((`QUAL_DELAY_NS * `CLK_MHZ) / 1000)
`define OTP_DELAY_US 2000
`define OTP_DELAY_CYC (`OTP_DELAY_US * `CLK_MHZ)
`define RETRY_PERIOD_MS 130
`define RETRY_PERIOD_CYC (`RETRY_PERIOD_MS * 1000 * `CLK_MHZ)
`define OTP_TRIP_C 8'h78
`define OTP_RESTART_C 8'h6E
`define OTW_LEVEL_C 8'h78
`define OTW_HYST_C 8'h03
`define TRACK_LIMIT_MV 16'h00FA
`define OVP_FLOOR_MV 16'h03E8
`define PG_UPPER_PCT 8'h6E
`define UV_BASE_PCT 8'h4B
`define PG_BASE_PCT 8'h5A
`define STEP_PCT 8'h05
`define UV_SEL_MAX 3'h3
`define PG_SEL_MAX 3'h1
`define ADR_CTRL 8'h00
`define ADR_SETPT 8'h04
`define ADR_STATUS 8'h08
`define ADR_MASK 8'h0C
`define ADR_STATE 8'h10
`define CTRL_RESET 32'h0000_0000
`define OV_PCT_RESET 8'h82
`define EV_OV 0
`define EV_UV 1
`define EV_TRK 2
`define EV_OT 3
`define EV_OTW 4
`define EV_PG 5
`endif

// ===== sim/pol_fault_checker.sv
// Purpose: port-level checks of the fault supervisor
// Assumes: one clock, synchronous active-high reset
// Notes: run counters mirror the qualification windows with a few cycles of slack
`timescale 1ns/1ps
module pol_fault_checker (
    input wire clk,
    input wire sys_rst,
    input wire [15:0] voutMv,
    input wire [7:0] tempC,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire wb_err_o,
    input wire turnOffReq,
    input wire otWarning,
    input wire power_good_out,
    input wire irq
);
    reg [31:0] hot_q;
    reg [31:0] cool_q;
    reg [31:0] steady_q;
    reg [15:0] vPrev_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // lengths of hot, cool and steady-output stretches
    always @(posedge clk) begin
        hot_q <= (sys_rst || tempC <= 8'h78) ? 32'h0000_0000 : hot_q + 32'h0000_0001;
        cool_q <= (sys_rst || tempC > 8'h75) ? 32'h0000_0000 : cool_q + 32'h0000_0001;
        steady_q <= (sys_rst || voutMv != vPrev_q) ? 32'h0000_0000 : steady_q + 32'h0000_0001;
        vPrev_q <= voutMv;
    end
    chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o)
        else $error("bus request not answered next cycle");
    chk_rst_quiet: assert property (disable iff (1'b0) sys_rst |=> !(turnOffReq | otWarning | power_good_out | irq))
        else $error("output high after reset");
    chk_warn_early: assert property ($rose(otWarning) |-> hot_q >= 32'h0000_05DB)
        else $error("warning before qualification");
    chk_warn_late: assert property (hot_q == 32'h0000_05E2 |-> otWarning)
        else $error("warning late");
    chk_warn_clear: assert property (otWarning |-> cool_q < 32'h0000_0640)
        else $error("warning stuck after cooling");
    chk_warn_fall: assert property ($fell(otWarning) |-> cool_q >= 32'h0000_0001)
        else $error("warning cleared while hot");
    chk_pg_qual: assert property ($changed(power_good_out) |-> steady_q >= 32'h0000_05DB)
        else $error("power good moved early");
endmodule
bind pol_fault_protection_monitor pol_fault_checker u_chk (.clk(clk), .sys_rst(sys_rst), .voutMv(voutMv),
    .tempC(tempC), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .turnOffReq(turnOffReq), .otWarning(otWarning), .power_good_out(power_good_out), .irq(irq));

// ===== sim/power_stage_model.sv
// Purpose: behavioural power stage facing the supervisor
// Assumes: levelMv is what the loop regulates to, injected faults included
// Notes: no slew; output collapses to zero while turn-off stands
`timescale 1ns/1ps
module power_stage_model (
    input wire clk,
    input wire offReq,
    input wire [15:0] levelMv,
    output reg [15:0] voutMv
);
    // one cycle of lag stands in for the output filter
    always @(posedge clk) begin
        voutMv <= offReq ? 16'h0000 : levelMv;
    end
endmodule

// ===== sim/tb_top.sv
// Purpose: self-checking bench for the fault supervisor
// Assumes: OT delay 50 and retry period 200 cycles via parameters
// Notes: every scenario starts from reset
`timescale 1ns/1ps
module tb_top;
    reg clk = 1'h0, rst = 1'h1, req = 1'h0, we = 1'h0, ramping = 1'h0, gotErr;
    reg [7:0] tempC = 8'h19;
    reg [15:0] levelMv = 16'h0000, rampMv = 16'h0000;
    reg [31:0] adr = 32'h0000_0000, wdat = 32'h0000_0000, rdat, tick = 32'h0000_0000;
    integer error_cnt = 0, cmp_count = 0;
    wire [15:0] vout;
    wire [31:0] dout;
    wire ack, err, off, warn, pg, irq;
    wire [3:0] outs = {irq, warn, pg, off};
    // short counts keep the run small
    pol_fault_protection_monitor #(.OTP_CYC(32'h0000_0032), .RETRY_CYC(32'h0000_00C8))
        u_pol_fault_protection_monitor (.clk(clk), .sys_rst(rst), .voutMv(vout), .rampTargetMv(rampMv),
        .ramping(ramping), .tempC(tempC), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_we_i(we),
        .wb_cyc_i(req), .wb_stb_i(req), .wb_dat_o(dout), .wb_ack_o(ack), .wb_err_o(err),
        .turnOffReq(off), .otWarning(warn), .power_good_out(pg), .irq(irq));
    power_stage_model u_power_stage_model (.clk(clk), .offReq(off), .levelMv(levelMv), .voutMv(vout));
    // clock, and a cycle limit so a hang ends as a mismatch
    always #2 clk = ~clk;
    always @(posedge clk) begin
        tick <= tick + 32'h0000_0001;
        if (tick == 32'h0000_C350) begin
            error_cnt = error_cnt + 1;
            end_of_test;
        end
    end
    task chk(input [31:0] got, input [31:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task hold(input integer n, input [1:0] w, input x);
        repeat (n) @(posedge clk);
        chk(outs[w], x);
    endtask
    // level step, no change just short of the delay, change soon after
    task qual(input [15:0] lv, input [1:0] w, input x);
        integer k;
        levelMv <= lv;
        hold(1480, w, ~x);
        for (k = 0; k < 60 && outs[w] !== x; k = k + 1) @(posedge clk);
        chk(outs[w], x);
    endtask
    // classic cycle held until ack or err is seen at an edge
    task bus(input w, input [31:0] a, input [31:0] d);
        @(posedge clk);
        req <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk);
        while ((ack | err) !== 1'h1) @(posedge clk);
        rdat = dout;
        gotErr = err;
        req <= 1'h0;
    endtask
    task rst5;
        @(posedge clk);
        rst <= 1'h1;
        repeat (5) @(posedge clk);
        rst <= 1'h0;
    endtask
    task t_ov;
        rst5;
        bus(1'h0, 32'h0000_0000, 32'h0000_0000);
        chk(rdat, 32'h0082_0000);
        bus(1'h1, 32'h0000_0040, 32'h0000_0000);
        chk(gotErr, 1'h1);
        bus(1'h1, 32'h0000_0004, 32'h0000_02BC);
        levelMv <= 16'h03B6;
        hold(1600, 2'h0, 1'h0);
        levelMv <= 16'h041A;
        hold(1000, 2'h0, 1'h0);
        levelMv <= 16'h03B6;
        hold(1600, 2'h0, 1'h0);
        qual(16'h041A, 2'h0, 1'h1);
        hold(3000, 2'h0, 1'h1);
        bus(1'h1, 32'h0000_0000, 32'h0082_0001);
        bus(1'h1, 32'h0000_0000, 32'h0082_0000);
        hold(3, 2'h0, 1'h0);
        $display("overvoltage test done");
    endtask
    task t_uv;
        rst5;
        bus(1'h1, 32'h0000_0004, 32'h0000_03E8);
        bus(1'h1, 32'h0000_000C, 32'h0000_0002);
        bus(1'h1, 32'h0000_0000, 32'h0082_00D1);
        qual(16'h0370, 2'h0, 1'h1);
        hold(3, 2'h3, 1'h1);
        bus(1'h0, 32'h0000_0008, 32'h0000_0000);
        chk(rdat & 32'h0000_0002, 32'h0000_0002);
        hold(2, 2'h3, 1'h0);
        hold(170, 2'h0, 1'h1);
        hold(30, 2'h0, 1'h0);
        hold(1520, 2'h0, 1'h1);
        $display("undervoltage test done");
    endtask
    task t_pg;
        rst5;
        bus(1'h1, 32'h0000_0004, 32'h0000_03E8);
        qual(16'h03E8, 2'h1, 1'h1);
        qual(16'h0460, 2'h1, 1'h0);
        qual(16'h0398, 2'h1, 1'h1);
        bus(1'h1, 32'h0000_0000, 32'h0082_0200);
        qual(16'h0398, 2'h1, 1'h0);
        $display("power good test done");
    endtask
    task t_ot;
        rst5;
        bus(1'h1, 32'h0000_0000, 32'h0082_0020);
        tempC <= 8'h78;
        hold(44, 2'h0, 1'h0);
        hold(12, 2'h0, 1'h1);
        hold(1500, 2'h2, 1'h0);
        chk(irq, 1'h0);
        bus(1'h0, 32'h0000_0008, 32'h0000_0000);
        chk(rdat & 32'h0000_0018, 32'h0000_0008);
        tempC <= 8'h7D;
        qual(levelMv, 2'h2, 1'h1);
        tempC <= 8'h76;
        hold(1600, 2'h2, 1'h1);
        tempC <= 8'h75;
        hold(1600, 2'h2, 1'h0);
        chk(off, 1'h1);
        tempC <= 8'h6E;
        hold(400, 2'h0, 1'h0);
        $display("overtemperature test done");
    endtask
    task t_trk;
        rst5;
        ramping <= 1'h1;
        rampMv <= 16'h01F4;
        levelMv <= 16'h0384;
        hold(1600, 2'h0, 1'h0);
        bus(1'h1, 32'h0000_0000, 32'h0082_0002);
        levelMv <= 16'h02E4;
        hold(1600, 2'h0, 1'h0);
        ramping <= 1'h0;
        levelMv <= 16'h0384;
        hold(1600, 2'h0, 1'h0);
        ramping <= 1'h1;
        qual(16'h00F0, 2'h0, 1'h1);
        $display("tracking test done");
    endtask
    task end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // scenarios in sequence, each from reset
    initial begin
        t_ov;
        t_uv;
        t_pg;
        t_ot;
        t_trk;
        end_of_test;
    end
endmodule

// ===== src/pol_fault_protection_monitor.v
// Purpose: fault supervisor of a digital point-of-load converter
// Assumes: measurements are synchronous words from the converter ADC path on clk
// Notes: registers over classic Wishbone, one-cycle ack; outputs from flip-flops
// Contract
// - OV, UV, tracking trip after 6 us
// - UV level 75..90 percent, 5 steps; the code clamps uv select to 3, giving 4 levels (75, 80, 85, 90)
// - OT shutdown 120 C, restart at 110 C
// - OT shutdown request after 2 ms
// - tracking only during ramp, 250 mV band
// - tracking off at reset, latch or retry
// - warning flag above 120 C, 3 C hysteresis
// - warning flag asserts after 6 us
// - power good high inside window only
// - window 90..95 percent to 110, 6 us
// - overvoltage level never below 1.0 V
//
// Implementation choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`include "pol_fault_defs.vh"
module pol_fault_protection_monitor #(
    parameter [31:0] OTP_CYC = `OTP_DELAY_CYC,
    parameter [31:0] RETRY_CYC = `RETRY_PERIOD_CYC
) (
    input wire clk,
    input wire sys_rst,
    input wire [15:0] voutMv,
    input wire [15:0] rampTargetMv,
    input wire ramping,
    input wire [7:0] tempC,
    input wire [31:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    input wire wb_we_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg wb_err_o,
    output reg turnOffReq,
    output reg otWarning,
    output reg power_good_out,
    output reg irq
);
    localparam ST_RUN = 2'b00;
    localparam ST_LATCH = 2'b01;
    localparam ST_RETRY = 2'b10;
    // ctrl: [0] enable, [1] track enable, [2] track retry, [3] ov retry, [4] uv retry,
    // [5] ot retry, [8:6] uv select, [11:9] pg select, [23:16] ov percent
    reg [31:0] ctrlQ;
    reg [15:0] setptQ;
    reg [5:0] statusQ;
    reg [5:0] maskQ;
    reg [1:0] stateQ;
    reg [31:0] retryQ;
    reg [3:0] causeQ;
    reg otShutQ;
    reg otwRawQ;
    reg pgPrevQ;
    reg enPrevQ;
    wire [3:0] faultQual;
    wire otwQual;
    wire pgQual;
    wire pgLowQual;
    wire [3:0] faultRaw;
    wire [31:0] sp32;
    wire [31:0] v100;
    wire [31:0] ovLevel;
    wire [31:0] ovFloor;
    wire [31:0] trackErr;
    wire [3:0] retryMode;
    wire otwSet;
    wire otwClr;
    wire busReq;
    wire [7:0] adr;

    // percentage of setpoint from a base and 5 percent steps, clamped to the max step
    function [7:0] pctOf;
        input [7:0] base;
        input [2:0] sel;
        input [2:0] selMax;
        reg [2:0] s;
        begin
            s = (sel > selMax) ? selMax : sel;
            pctOf = base + (`STEP_PCT * {5'h00, s});
        end
    endfunction

    // compare vout*100 against setpoint*pct, avoiding any division
    function [31:0] spTimes;
        input [15:0] sp;
        input [7:0] pct;
        begin
            spTimes = {16'h0000, sp} * {24'h00_0000, pct};
        end
    endfunction

    assign sp32 = {16'h0000, setptQ};
    assign v100 = {16'h0000, voutMv} * 32'h0000_0064;
    assign ovLevel = spTimes(setptQ, ctrlQ[23:16]);
    assign ovFloor = {16'h0000, `OVP_FLOOR_MV} * 32'h0000_0064;
    assign trackErr = (voutMv > rampTargetMv) ? {16'h0000, voutMv - rampTargetMv}
                                              : {16'h0000, rampTargetMv - voutMv};
    // level compares; floor applies to the ov level only
    assign faultRaw[`EV_OV] = v100 > ((ovLevel < ovFloor) ? ovFloor : ovLevel);
    assign faultRaw[`EV_UV] = ctrlQ[0] && !ramping &&
        (v100 < spTimes(setptQ, pctOf(`UV_BASE_PCT, ctrlQ[8:6], `UV_SEL_MAX)));
    assign faultRaw[`EV_TRK] = ctrlQ[1] && ramping && (trackErr > {16'h0000, `TRACK_LIMIT_MV});
    assign faultRaw[`EV_OT] = tempC >= `OTP_TRIP_C;
    // retry bits reordered to the event order ov, uv, trk, ot
    assign retryMode = {ctrlQ[5], ctrlQ[2], ctrlQ[4], ctrlQ[3]};

    // 6 us qualification for the fast faults, 2 ms for temperature
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : fastQual
            qual_timer #(.COUNT(`QUAL_DELAY_CYC)) uQual (
                .clk(clk),
                .sys_rst(sys_rst),
                .raw(faultRaw[gi] && !turnOffReq), // collapse while off must not pre-qualify a retrip
                .qualified(faultQual[gi])
            );
        end
    endgenerate
    qual_timer #(.COUNT(OTP_CYC)) uOtQual (
        .clk(clk),
        .sys_rst(sys_rst),
        .raw(faultRaw[`EV_OT]),
        .qualified(faultQual[`EV_OT])
    );

    // warning raw level with 3 C hysteresis: set above 120, clear at or below 117
    assign otwSet = tempC > `OTW_LEVEL_C;
    assign otwClr = tempC <= (`OTW_LEVEL_C - `OTW_HYST_C);
    always @(posedge clk) begin
        if (sys_rst) begin
            otwRawQ <= 1'b0;
        end else if (otwSet) begin
            otwRawQ <= 1'b1;
        end else if (otwClr) begin
            otwRawQ <= 1'b0;
        end
    end
    qual_timer #(.COUNT(`QUAL_DELAY_CYC)) uOtwQual (
        .clk(clk),
        .sys_rst(sys_rst),
        .raw(otwRawQ),
        .qualified(otwQual)
    );

    // power good window, each direction qualified by 6 us before the pin moves
    wire pgInside;
    assign pgInside = (v100 >= spTimes(setptQ, pctOf(`PG_BASE_PCT, ctrlQ[11:9], `PG_SEL_MAX))) &&
                      (v100 <= spTimes(setptQ, `PG_UPPER_PCT));
    qual_timer #(.COUNT(`QUAL_DELAY_CYC)) uPgIn (
        .clk(clk),
        .sys_rst(sys_rst),
        .raw(pgInside),
        .qualified(pgQual)
    );
    qual_timer #(.COUNT(`QUAL_DELAY_CYC)) uPgOut (
        .clk(clk),
        .sys_rst(sys_rst),
        .raw(!pgInside),
        .qualified(pgLowQual)
    );
    always @(posedge clk) begin
        if (sys_rst) begin
            power_good_out <= 1'b0;
        end else if (pgQual) begin
            power_good_out <= 1'b1;
        end else if (pgLowQual) begin
            power_good_out <= 1'b0;
        end
    end

    // over-temperature shutdown holds until the junction cools to 110 C
    always @(posedge clk) begin
        if (sys_rst) begin
            otShutQ <= 1'b0;
        end else if (faultQual[`EV_OT]) begin
            otShutQ <= 1'b1;
        end else if (tempC <= `OTP_RESTART_C) begin
            otShutQ <= 1'b0;
        end
    end

    // fault response: latch waits for software to clear enable, retry restarts each period
    always @(posedge clk) begin
        if (sys_rst) begin
            stateQ <= ST_RUN;
            retryQ <= 32'h0000_0000;
            causeQ <= 4'h0;
            turnOffReq <= 1'b0;
            enPrevQ <= 1'b0;
        end else begin
            enPrevQ <= ctrlQ[0];
            case (stateQ)
                ST_RUN: begin
                    turnOffReq <= 1'b0;
                    if (|faultQual[2:0] || faultQual[`EV_OT]) begin
                        turnOffReq <= 1'b1;
                        causeQ <= faultQual;
                        retryQ <= 32'h0000_0000;
                        if ((faultQual & ~retryMode) != 4'h0) begin
                            stateQ <= ST_LATCH;
                        end else begin
                            stateQ <= ST_RETRY;
                        end
                    end
                end
                ST_LATCH: begin
                    turnOffReq <= 1'b1;
                    // only an explicit clear of enable re-arms, never a hot junction
                    if (enPrevQ && !ctrlQ[0] && !otShutQ) begin
                        stateQ <= ST_RUN; // software clears enable to re-arm
                        turnOffReq <= 1'b0;
                    end
                end
                ST_RETRY: begin
                    turnOffReq <= 1'b1;
                    if (retryQ >= RETRY_CYC - 32'h0000_0001) begin
                        retryQ <= 32'h0000_0000;
                        if (!otShutQ) begin
                            stateQ <= ST_RUN;
                            turnOffReq <= 1'b0;
                        end
                    end else begin
                        retryQ <= retryQ + 32'h0000_0001;
                    end
                end
                default: begin
                    stateQ <= ST_RUN;
                end
            endcase
        end
    end

    // warning output follows the qualified level
    always @(posedge clk) begin
        if (sys_rst) begin
            otWarning <= 1'b0;
        end else begin
            otWarning <= otwQual;
        end
    end

    // register slave: single-cycle ack, err on unmapped word
    assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign adr = wb_adr_i[7:0];
    wire mapped;
    assign mapped = (wb_adr_i[31:8] == 24'h00_0000) &&
        ((adr == `ADR_CTRL) || (adr == `ADR_SETPT) || (adr == `ADR_STATUS) ||
         (adr == `ADR_MASK) || (adr == `ADR_STATE));
    wire statusRd;
    assign statusRd = busReq && mapped && !wb_we_i && (adr == `ADR_STATUS);
    wire [5:0] events;
    assign events = {pgQual & !pgPrevQ, otwQual & !otWarning, faultQual & ~causeQ & {4{stateQ == ST_RUN}}};

    integer b;
    always @(posedge clk) begin
        if (sys_rst) begin
            ctrlQ <= `CTRL_RESET | {8'h00, `OV_PCT_RESET, 16'h0000}; // tracking off
            setptQ <= 16'h0000;
            maskQ <= 6'h00;
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= busReq && mapped;
            wb_err_o <= busReq && !mapped;
            if (busReq && mapped && wb_we_i) begin
                for (b = 0; b < 4; b = b + 1) begin
                    if (wb_sel_i[b] && adr == `ADR_CTRL) begin
                        ctrlQ[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
                    end
                end
                if (adr == `ADR_SETPT) begin
                    if (wb_sel_i[0]) setptQ[7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1]) setptQ[15:8] <= wb_dat_i[15:8];
                end else if (adr == `ADR_MASK && wb_sel_i[0]) begin
                    maskQ <= wb_dat_i[5:0];
                end
            end
            if (busReq && mapped && !wb_we_i) begin
                if (adr == `ADR_CTRL) begin
                    wb_dat_o <= ctrlQ;
                end else if (adr == `ADR_SETPT) begin
                    wb_dat_o <= {16'h0000, setptQ};
                end else if (adr == `ADR_STATUS) begin
                    wb_dat_o <= {26'h000_0000, statusQ};
                end else if (adr == `ADR_MASK) begin
                    wb_dat_o <= {26'h000_0000, maskQ};
                end else begin
                    wb_dat_o <= {20'h0_0000, causeQ, 1'b0, otShutQ, stateQ, 1'b0, power_good_out,
                                 otWarning, turnOffReq};
                end
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    // sticky status, read clears; a new event in the read cycle survives
    always @(posedge clk) begin
        if (sys_rst) begin
            statusQ <= 6'h00;
            pgPrevQ <= 1'b0;
            irq <= 1'b0;
        end else begin
            pgPrevQ <= pgQual;
            statusQ <= (statusRd ? 6'h00 : statusQ) | events;
            irq <= |(((statusRd ? 6'h00 : statusQ) | events) & maskQ);
        end
    end
endmodule

// ===== src/qual_timer.v
// Purpose: qualifies a raw fault level by a fixed delay
// Assumes: raw input is synchronous to clk
// Notes: output rises only after raw stays high for the full count, falls at once
`timescale 1ns/1ps
`include "pol_fault_defs.vh"
module qual_timer #(
    parameter [31:0] COUNT = 32'h0000_05DC
) (
    input wire clk,
    input wire sys_rst,
    input wire raw,
    output reg qualified
);
    reg [31:0] cnt_q;
    // a short glitch restarts the count so it never trips
    always @(posedge clk) begin
        if (sys_rst) begin
            cnt_q <= 32'h0000_0000;
            qualified <= 1'b0;
        end else if (!raw) begin
            cnt_q <= 32'h0000_0000;
            qualified <= 1'b0;
        end else if (cnt_q >= COUNT - 32'h0000_0001) begin
            qualified <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
        end
    end
endmodule
